// *** tb/fhs_led_props.sv ***
// checker: led colour against the delayed sensing inputs
`timescale 1ns/100ps
`default_nettype none
module fhs_led_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic exhaust_temp_over_limit,
	input wire logic fan_stopped,
	input wire logic fan_low_speed,
	input wire logic supply_rail_a,
	input wire logic supply_rail_b,
	input wire logic supply_module_a_present,
	input wire logic supply_module_b_present,
	input wire logic led_red,
	input wire logic led_green
);
	logic [3:0] live;
	logic [3:0] d1;
	logic [3:0] d2;
	logic [3:0] d3;
	logic [1:0] age;
	assign live = {fan_low_speed,
		(~supply_rail_a | ~supply_rail_b) &
		(supply_module_a_present | supply_module_b_present),
		fan_stopped, exhaust_temp_over_limit};
	// led lags the inputs by three edges; age hides the reset-time copies
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age <= 2'h0;
			d1 <= 4'h0;
			d2 <= 4'h0;
			d3 <= 4'h0;
		end else begin
			if (age != 2'h3) age <= age + 2'h1;
			d1 <= live;
			d2 <= d1;
			d3 <= d2;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence settled_s(logic [3:0] m, logic [3:0] v);
		age == 2'h3 && (d3 & m) == v;
	endsequence
	temp_red_a: assert property (
		settled_s(4'h1, 4'h1) |-> !led_green) else $error("green on hot");
	fan_stop_a: assert property (
		settled_s(4'h3, 4'h2) |-> led_red == led_green)
		else $error("fan stop not yellow");
	rail_red_a: assert property (
		settled_s(4'h7, 4'h4) |-> led_red && !led_green)
		else $error("rail fault not red");
	slow_yellow_a: assert property (
		settled_s(4'hF, 4'h8) |-> led_red && led_green)
		else $error("slow fan not yellow");
	rail_masked_a: assert property (
		settled_s(4'h7, 4'h6) |-> led_red == led_green)
		else $error("rail not masked");
	all_good_a: assert property (
		settled_s(4'hF, 4'h0) |-> !led_red && led_green)
		else $error("good not green");
endmodule : fhs_led_props
bind fhs_frame_health_status_led fhs_led_props u_props (
	.pclk(pclk), .presetn(presetn),
	.exhaust_temp_over_limit(exhaust_temp_over_limit),
	.fan_stopped(fan_stopped), .fan_low_speed(fan_low_speed),
	.supply_rail_a(supply_rail_a), .supply_rail_b(supply_rail_b),
	.supply_module_a_present(supply_module_a_present),
	.supply_module_b_present(supply_module_b_present),
	.led_red(led_red), .led_green(led_green));
`default_nettype wire

// *** tb/fhs_sense_model.sv ***
// frame sensing model: fan, exhaust temperature and supply signals
`timescale 1ns/100ps
`default_nettype none
module fhs_sense_model (
	input wire logic [6:0] req,
	output wire logic exhaust_temp_over_limit,
	output wire logic fan_stopped,
	output wire logic fan_low_speed,
	output wire logic supply_rail_a,
	output wire logic supply_rail_b,
	output wire logic supply_module_a_present,
	output wire logic supply_module_b_present
);
	assign exhaust_temp_over_limit = req[0];
	assign fan_stopped = req[1];
	// a stopped fan is also below normal speed, so both flags rise
	assign fan_low_speed = req[1] | req[2];
	assign supply_module_a_present = req[3];
	assign supply_module_b_present = req[4];
	// an absent module gives no rail
	assign supply_rail_a = req[3] & ~req[5];
	assign supply_rail_b = req[4] & ~req[6];
endmodule : fhs_sense_model
`default_nettype wire

// *** tb/frame_health_status_led_tb.sv ***
// testbench: register access, led priority table and interrupt path
`timescale 1ns/100ps
`default_nettype none
module frame_health_status_led_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, led_red, led_green, irq;
	logic [6:0] req = 7'h18;
	wire logic tmp, stp, slw, ra, rb, pa, pb;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	int hi, lo, gbad;
	// {db, da, pb, pa, slow, stop, temp, alarm code}
	localparam logic [9:0] TBL [9] = '{10'h0C0, 10'h0E4, 10'h1C3,
		10'h1E3, 10'h0D2, 10'h1D2, 10'h3F9, 10'h000, 10'h043};
	always #10 pclk = ~pclk;
	fhs_sense_model model (.req(req), .exhaust_temp_over_limit(tmp),
		.fan_stopped(stp), .fan_low_speed(slw), .supply_rail_a(ra),
		.supply_rail_b(rb), .supply_module_a_present(pa),
		.supply_module_b_present(pb));
	fhs_frame_health_status_led #(.FLASH_HALF_CYCLES(32'h4)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exhaust_temp_over_limit(tmp),
		.fan_stopped(stp), .fan_low_speed(slw), .supply_rail_a(ra),
		.supply_rail_b(rb), .supply_module_a_present(pa),
		.supply_module_b_present(pb), .led_red(led_red),
		.led_green(led_green), .irq(irq));
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [2:0] led_of(input logic [2:0] code);
		case (code)
			3'h1: return 3'b110;
			3'h2: return 3'b111;
			3'h3: return 3'b010;
			3'h4: return 3'b011;
			default: return 3'b001;
		endcase
	endfunction : led_of
	// e is {flashing, red, green}; sampled across more than a full period
	task chk_led(input logic [2:0] e);
		hi = 0;
		lo = 0;
		gbad = 0;
		repeat (4) @(posedge pclk);
		repeat (10) begin
			@(negedge pclk);
			if (led_red === 1'b1) hi++;
			else lo++;
			if (led_green !== (e[2] ? e[0] & led_red : e[0])) gbad++;
		end
		chk({29'h0, hi != 0, lo != 0, gbad != 0},
			{29'h0, e[2] | e[1], e[2] | ~e[1], 1'b0});
	endtask : chk_led
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, fhs_pkg::FHS_OFS_ENABLE, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, fhs_pkg::FHS_OFS_CTRL, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, fhs_pkg::FHS_OFS_CLEAR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, fhs_pkg::FHS_OFS_ENABLE, 32'h1F);
		apb(1'b1, fhs_pkg::FHS_OFS_CLEAR, 32'h1F);
		for (int i = 0; i < 9; i++) begin
			req <= TBL[i][9:3];
			chk_led(led_of(TBL[i][2:0]));
			apb(1'b0, fhs_pkg::FHS_OFS_COND, 32'h0);
			chk({29'h0, rd[6:4]}, {29'h0, TBL[i][2:0]});
		end
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, fhs_pkg::FHS_OFS_STATUS, 32'h0);
		chk(rd, 32'h1F);
		apb(1'b1, fhs_pkg::FHS_OFS_ENABLE, 32'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, fhs_pkg::FHS_OFS_ENABLE, 32'h10);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, fhs_pkg::FHS_OFS_CLEAR, 32'h10);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, fhs_pkg::FHS_OFS_STATUS, 32'h0);
		chk(rd, 32'h0F);
		// fan stop keeps the led props quiet under lamp test and blanking
		req <= 7'h1A;
		chk_led(3'b111);
		apb(1'b1, fhs_pkg::FHS_OFS_CTRL, 32'h3);
		chk_led(3'b011);
		apb(1'b0, fhs_pkg::FHS_OFS_COND, 32'h0);
		chk({21'h0, rd[9:0], err}, 32'h654);
		apb(1'b1, fhs_pkg::FHS_OFS_CTRL, 32'h2);
		chk_led(3'b000);
		apb(1'b1, fhs_pkg::FHS_OFS_CTRL, 32'h1);
		apb(1'b0, fhs_pkg::FHS_OFS_CTRL, 32'h0);
		chk(rd, 32'h1);
		chk_led(3'b111);
		end_of_test();
	end
endmodule : frame_health_status_led_tb
`default_nettype wire

// *** verilog/fhs_flash_div.sv ***
// flash rate divider: one-cycle tick and a phase that toggles on it
`timescale 1ns/100ps
`default_nettype none
module fhs_flash_div #(
	parameter logic [31:0] HALF_CYCLES = 32'h0000_0002
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick_o,
	output logic phase_o
);

	logic [31:0] cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 32'h0000_0000;
			tick_o <= 1'b0;
		end else if (cnt_r >= HALF_CYCLES - 32'h0000_0001) begin
			cnt_r <= 32'h0000_0000;
			tick_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
			tick_o <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_o <= 1'b1;
		end else if (tick_o) begin
			phase_o <= ~phase_o;
		end
	end

endmodule : fhs_flash_div
`default_nettype wire

// *** verilog/fhs_frame_health_status_led.sv ***
// frame health indicator: priority selector, bi-colour led drive, apb regs
`timescale 1ns/100ps
`default_nettype none
module fhs_frame_health_status_led #(
	parameter logic [31:0] FLASH_HALF_CYCLES = fhs_pkg::FHS_FLASH_HALF_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// frame sensing inputs
	input wire logic exhaust_temp_over_limit,
	input wire logic fan_stopped,
	input wire logic fan_low_speed,
	input wire logic supply_rail_a,
	input wire logic supply_rail_b,
	input wire logic supply_module_a_present,
	input wire logic supply_module_b_present,
	// bi-colour led: red and green together show yellow
	output logic led_red,
	output logic led_green,
	output logic irq
);

	// input sampling and condition decode
	// rails reset as present so release shows no false rail fault
	logic temp_r;
	logic fan_stop_r;
	logic fan_slow_r;
	logic rail_a_r;
	logic rail_b_r;
	logic mod_a_r;
	logic mod_b_r;

	// inputs are synchronous; one stage keeps decode off the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_r <= 1'b0;
			fan_stop_r <= 1'b0;
			fan_slow_r <= 1'b0;
			rail_a_r <= 1'b1;
			rail_b_r <= 1'b1;
			mod_a_r <= 1'b0;
			mod_b_r <= 1'b0;
		end else begin
			temp_r <= exhaust_temp_over_limit;
			fan_stop_r <= fan_stopped;
			fan_slow_r <= fan_low_speed;
			rail_a_r <= supply_rail_a;
			rail_b_r <= supply_rail_b;
			mod_a_r <= supply_module_a_present;
			mod_b_r <= supply_module_b_present;
		end
	end

	logic rail_fault;
	logic [3:0] live;

	// either rail gone while at least one module reports present
	assign rail_fault = (~rail_a_r | ~rail_b_r) & (mod_a_r | mod_b_r);

	always_comb begin
		live = 4'h0;
		live[fhs_pkg::FHS_EVT_TEMP] = temp_r;
		live[fhs_pkg::FHS_EVT_FAN_STOP] = fan_stop_r;
		live[fhs_pkg::FHS_EVT_RAIL] = rail_fault;
		live[fhs_pkg::FHS_EVT_FAN_SLOW] = fan_slow_r;
	end

	// priority selector
	// a single registered code feeds both the led and the cond register,
	// so software never reads a colour the led is not showing
	fhs_pkg::fhs_alarm_t alarm_nxt;
	fhs_pkg::fhs_alarm_t alarm_r;

	// lower alarms stay hidden while a higher one is active
	always_comb begin
		if (temp_r) begin
			alarm_nxt = fhs_pkg::FHS_ALM_TEMP;
		end else if (fan_stop_r) begin
			alarm_nxt = fhs_pkg::FHS_ALM_FAN_STOP;
		end else if (rail_fault) begin
			alarm_nxt = fhs_pkg::FHS_ALM_RAIL;
		end else if (fan_slow_r) begin
			alarm_nxt = fhs_pkg::FHS_ALM_FAN_SLOW;
		end else begin
			alarm_nxt = fhs_pkg::FHS_ALM_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_r <= fhs_pkg::FHS_ALM_NONE;
		end else begin
			alarm_r <= alarm_nxt;
		end
	end

	// flash timing
	// one shared divider keeps red and green in step for flashing yellow
	logic flash_phase;

	fhs_flash_div #(
		.HALF_CYCLES(FLASH_HALF_CYCLES)
	) u_flash_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_o(),
		.phase_o(flash_phase)
	);

	// control register and led drive
	// led enable is applied last so it beats lamp test
	// the led lags an input change by three edges: sample, select, drive
	logic [1:0] ctrl_r;
	logic red_nxt;
	logic green_nxt;

	always_comb begin
		red_nxt = 1'b0;
		green_nxt = 1'b0;
		unique case (alarm_r)
			fhs_pkg::FHS_ALM_TEMP: begin
				red_nxt = flash_phase;
			end
			fhs_pkg::FHS_ALM_FAN_STOP: begin
				red_nxt = flash_phase;
				green_nxt = flash_phase;
			end
			fhs_pkg::FHS_ALM_RAIL: begin
				red_nxt = 1'b1;
			end
			fhs_pkg::FHS_ALM_FAN_SLOW: begin
				red_nxt = 1'b1;
				green_nxt = 1'b1;
			end
			fhs_pkg::FHS_ALM_NONE: begin
				green_nxt = 1'b1;
			end
			default: begin
				red_nxt = 1'b0;
				green_nxt = 1'b0;
			end
		endcase
		// lamp test lights both dies steady; disabling blanks the led
		if (ctrl_r[fhs_pkg::FHS_CTRL_LAMP_TEST]) begin
			red_nxt = 1'b1;
			green_nxt = 1'b1;
		end
		if (!ctrl_r[fhs_pkg::FHS_CTRL_LED_EN]) begin
			red_nxt = 1'b0;
			green_nxt = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_red <= 1'b0;
			led_green <= 1'b0;
		end else begin
			led_red <= red_nxt;
			led_green <= green_nxt;
		end
	end

	// event detection
	// good_prev_r resets high so reset raises no return-to-good event;
	// a condition already present at release still raises its event
	logic [3:0] live_prev_r;
	logic good_prev_r;
	logic [fhs_pkg::FHS_EVT_W-1:0] evt_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_prev_r <= 4'h0;
			good_prev_r <= 1'b1;
		end else begin
			live_prev_r <= live;
			good_prev_r <= (alarm_r == fhs_pkg::FHS_ALM_NONE);
		end
	end

	// rising edges of each condition, plus return to all good
	always_comb begin
		evt_set = {1'b0, live & ~live_prev_r};
		evt_set[fhs_pkg::FHS_EVT_GOOD] =
			(alarm_r == fhs_pkg::FHS_ALM_NONE) & ~good_prev_r;
	end

	// apb access decode
	// full address compare: aliases of a register answer with pslverr
	// no wait states are ever needed, so pready is a constant high
	logic setup_ph;
	logic wr_acc;
	logic hit_status;
	logic hit_clear;
	logic hit_enable;
	logic hit_cond;
	logic hit_ctrl;
	logic mapped;

	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign hit_status = (paddr == fhs_pkg::FHS_OFS_STATUS);
	assign hit_clear = (paddr == fhs_pkg::FHS_OFS_CLEAR);
	assign hit_enable = (paddr == fhs_pkg::FHS_OFS_ENABLE);
	assign hit_cond = (paddr == fhs_pkg::FHS_OFS_COND);
	assign hit_ctrl = (paddr == fhs_pkg::FHS_OFS_CTRL);
	assign mapped = hit_status | hit_clear | hit_enable | hit_cond | hit_ctrl;

	// read data is latched in setup, so every access takes two cycles: setup and one access cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// sticky status, enable, interrupt
	// irq is registered, so it trails a status or enable change by one edge
	logic [fhs_pkg::FHS_EVT_W-1:0] status;
	logic [fhs_pkg::FHS_EVT_W-1:0] clr_req;
	logic [fhs_pkg::FHS_EVT_W-1:0] enable_r;

	assign clr_req = (wr_acc & hit_clear) ?
		pwdata[fhs_pkg::FHS_EVT_W-1:0] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < fhs_pkg::FHS_EVT_W; gi++) begin : g_evt
			fhs_sticky_bit #(
				.RESET_VAL(1'b0)
			) u_bit (
				.pclk(pclk),
				.presetn(presetn),
				.set_i(evt_set[gi]),
				.clr_i(clr_req[gi]),
				.q_o(status[gi])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= fhs_pkg::FHS_ENABLE_RST;
		end else if (wr_acc & hit_enable) begin
			enable_r <= pwdata[fhs_pkg::FHS_EVT_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= fhs_pkg::FHS_CTRL_RST;
		end else if (wr_acc & hit_ctrl) begin
			ctrl_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & enable_r);
		end
	end

	// read data
	// latched once in setup; the value stands until the next read
	// so a slow master still sees one consistent snapshot
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (hit_status) begin
			rd_nxt[fhs_pkg::FHS_EVT_W-1:0] = status;
		end else if (hit_enable) begin
			rd_nxt[fhs_pkg::FHS_EVT_W-1:0] = enable_r;
		end else if (hit_cond) begin
			rd_nxt[fhs_pkg::FHS_COND_LIVE_LSB +: 4] = live;
			rd_nxt[fhs_pkg::FHS_COND_ALARM_LSB +: 3] = alarm_r;
			rd_nxt[fhs_pkg::FHS_COND_RED] = led_red;
			rd_nxt[fhs_pkg::FHS_COND_GREEN] = led_green;
			rd_nxt[fhs_pkg::FHS_COND_PHASE] = flash_phase;
		end else if (hit_ctrl) begin
			rd_nxt[1:0] = ctrl_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph & ~pwrite) begin
			prdata <= rd_nxt;
		end
	end

endmodule : fhs_frame_health_status_led
`default_nettype wire

// *** verilog/fhs_pkg.sv ***
// package: register map, field layout and timing for the frame health led
// What this block does
// - over-temperature exhaust air: flashing red, top priority
// - fan stopped: flashing yellow, second priority
// - rail missing, module present: steady red, third
// - fan slow: steady yellow, fourth priority
// - show only highest active alarm, mask lower
package fhs_pkg;

	// apb register byte offsets
	localparam logic [11:0] FHS_OFS_STATUS = 12'h000;
	localparam logic [11:0] FHS_OFS_CLEAR = 12'h004;
	localparam logic [11:0] FHS_OFS_ENABLE = 12'h008;
	localparam logic [11:0] FHS_OFS_COND = 12'h00C;
	localparam logic [11:0] FHS_OFS_CTRL = 12'h010;

	// event bits, shared by status, clear and enable
	localparam int FHS_EVT_TEMP = 0;
	localparam int FHS_EVT_FAN_STOP = 1;
	localparam int FHS_EVT_RAIL = 2;
	localparam int FHS_EVT_FAN_SLOW = 3;
	localparam int FHS_EVT_GOOD = 4;
	localparam int FHS_EVT_W = 5;
	localparam logic [FHS_EVT_W-1:0] FHS_ENABLE_RST = 5'h00;

	// condition register fields
	localparam int FHS_COND_LIVE_LSB = 0;
	localparam int FHS_COND_ALARM_LSB = 4;
	localparam int FHS_COND_RED = 8;
	localparam int FHS_COND_GREEN = 9;
	localparam int FHS_COND_PHASE = 10;

	// control register fields
	localparam int FHS_CTRL_LED_EN = 0;
	localparam int FHS_CTRL_LAMP_TEST = 1;
	localparam logic [1:0] FHS_CTRL_RST = 2'h1;

	// timing
	localparam longint FHS_CLK_HZ = 50000000;
	localparam longint FHS_FLASH_HALF_MS = 250;
	localparam logic [31:0] FHS_FLASH_HALF_CYCLES =
		32'(FHS_CLK_HZ * FHS_FLASH_HALF_MS / 1000);

	typedef enum logic [2:0] {
		FHS_ALM_NONE = 3'b000,
		FHS_ALM_TEMP = 3'b001,
		FHS_ALM_FAN_STOP = 3'b010,
		FHS_ALM_RAIL = 3'b011,
		FHS_ALM_FAN_SLOW = 3'b100
	} fhs_alarm_t;

endpackage : fhs_pkg

// *** verilog/fhs_sticky_bit.sv ***
// sticky event flag with software clear; a set in the clear cycle wins
`timescale 1ns/100ps
`default_nettype none
module fhs_sticky_bit #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set_i,
	input wire logic clr_i,
	output logic q_o
);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_o <= RESET_VAL;
		end else if (set_i) begin
			q_o <= 1'b1;
		end else if (clr_i) begin
			q_o <= 1'b0;
		end
	end

endmodule : fhs_sticky_bit
`default_nettype wire
